// *** rtl/tccu_timer0.sv ***
// Purpose: 8-bit timer/counter with prescaled or external ticks and two compare units
// Assumes: cpu strobes are one-cycle pulses synchronous to clk
// Notes:   flags are set-wins-over-clear; port override follows the output action only

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - prescaler free-runs, so first prescaled tick comes 1 to N cycles after enable.
// - external count input is sampled every clock through a rising-edge synchroniser.
// - one tick per rising edge at select 7, per falling edge at select 6.
// - external edge reaches the counter within 3 to 4 clock cycles.
// - external ticks feed the counter directly, bypassing the prescaler.
// - select 0 stops the counter; cpu can still read and write it.
// - each tick clears, increments or decrements the counter per waveform mode.
// - a cpu counter write beats any clear or count in the same cycle.
// - overflow flag is set per waveform mode and can request an interrupt.
// - equality with a compare value sets its flag on the following tick.
// - a compare flag clears on interrupt service or on software writing one.
// - in pwm modes compare writes are buffered and loaded at top.
// - force strobe in non-pwm modes acts like a match, no flag, no clear.
// - any cpu counter write blocks every compare match on the next tick.
// - output action field is live, taking effect from the next match.
// - reset clears compare output bits; mode changes leave them untouched.
// - nonzero output action replaces port value; direction stays with port.
// - port override ignores the waveform mode.
// - output action zero never changes the compare output bit.
// - select 1 ticks every clock; selects 2 to 5 use taps 8, 64, 256, 1024.
// - bottom means 0x00 and max means 0xFF.
// - normal mode sets overflow in the tick that wraps to zero.
module tccu_timer0 (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       external_count_input,
  input  wire logic [2:0] tick_source_select,
  input  wire logic [2:0] waveform_mode,
  input  wire logic [1:0] output_action_field_a,
  input  wire logic [1:0] output_action_field_b,
  input  wire logic       force_match_strobe_a,
  input  wire logic       force_match_strobe_b,
  input  wire logic       count_wr,
  input  wire logic [7:0] count_wr_data,
  input  wire logic       compare_a_wr,
  input  wire logic [7:0] compare_a_wr_data,
  input  wire logic       compare_b_wr,
  input  wire logic [7:0] compare_b_wr_data,
  input  wire logic       overflow_flag_wr_one,
  input  wire logic       match_flag_a_wr_one,
  input  wire logic       match_flag_b_wr_one,
  input  wire logic       overflow_irq_ack,
  input  wire logic       match_a_irq_ack,
  input  wire logic       match_b_irq_ack,
  input  wire logic       overflow_irq_en,
  input  wire logic       match_a_irq_en,
  input  wire logic       match_b_irq_en,
  input  wire logic [1:0] port_value,
  input  wire logic [1:0] port_dir,
  output logic [7:0]      count_value,
  output logic [7:0]      compare_value_a,
  output logic [7:0]      compare_value_b,
  output logic            overflow_flag,
  output logic            match_flag_a,
  output logic            match_flag_b,
  output logic            overflow_irq,
  output logic            match_a_irq,
  output logic            match_b_irq,
  output logic            compare_output_a,
  output logic            compare_output_b,
  output logic [1:0]      pin_out,
  output logic [1:0]      pin_oe
);

  // ****************************************************************
  // decoding shared by both compare units
  // ****************************************************************
  function automatic logic tccu_is_pwm(input logic [2:0] wgm);
    tccu_is_pwm = (wgm == tccu_pkg::WGM_PC_MAX)   || (wgm == tccu_pkg::WGM_FAST_MAX) ||
                  (wgm == tccu_pkg::WGM_PC_OCRA)  || (wgm == tccu_pkg::WGM_FAST_OCRA);
  endfunction : tccu_is_pwm

  function automatic logic tccu_is_fast(input logic [2:0] wgm);
    tccu_is_fast = (wgm == tccu_pkg::WGM_FAST_MAX) || (wgm == tccu_pkg::WGM_FAST_OCRA);
  endfunction : tccu_is_fast

  function automatic logic tccu_is_pc(input logic [2:0] wgm);
    tccu_is_pc = (wgm == tccu_pkg::WGM_PC_MAX) || (wgm == tccu_pkg::WGM_PC_OCRA);
  endfunction : tccu_is_pc

  // next compare output bit; wrap is the top-to-bottom step of fast pwm
  function automatic logic tccu_oc_next(
    input logic       oc,
    input logic [1:0] com,
    input logic [2:0] wgm,
    input logic       unit_a,
    input logic       dir_down,
    input logic       match,
    input logic       force_hit,
    input logic       wrap
  );
    logic res;
    res = oc;
    if (com == tccu_pkg::COM_NONE) begin
      res = oc;
    end else if (!tccu_is_pwm(wgm)) begin
      if (match || force_hit) begin
        unique case (com)
          tccu_pkg::COM_TOGGLE: res = ~oc;
          tccu_pkg::COM_CLEAR:  res = 1'b0;
          tccu_pkg::COM_SET:    res = 1'b1;
          default:              res = oc;
        endcase
      end
    end else if (com == tccu_pkg::COM_TOGGLE) begin
      // toggle in pwm is only offered on unit a with the top-from-compare modes
      if (match && unit_a && wgm[2]) begin
        res = ~oc;
      end
    end else if (tccu_is_fast(wgm)) begin
      // the bottom event wins so that compare at max gives a steady level
      if (wrap) begin
        res = (com == tccu_pkg::COM_CLEAR);
      end else if (match) begin
        res = (com == tccu_pkg::COM_SET);
      end
    end else if (match) begin
      res = (com == tccu_pkg::COM_SET) ^ dir_down;
    end
    tccu_oc_next = res;
  endfunction : tccu_oc_next

  // ****************************************************************
  // tick source: free prescaler, taps and external edges
  // ****************************************************************
  logic [tccu_pkg::PRESC_W-1:0] presc_q;
  logic                         ext_rise;
  logic                         ext_fall;
  logic                         tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 10'h001;
    end
  end

  tccu_ext_edge tccu_ext_edge_inst (
    .clk        (clk),
    .rst_b      (rst_b),
    .pin_in     (external_count_input),
    .rise_pulse (ext_rise),
    .fall_pulse (ext_fall)
  );

  wire tap8    = &(presc_q | ~tccu_pkg::TAP8_MASK);
  wire tap64   = &(presc_q | ~tccu_pkg::TAP64_MASK);
  wire tap256  = &(presc_q | ~tccu_pkg::TAP256_MASK);
  wire tap1024 = &(presc_q | ~tccu_pkg::TAP1024_MASK);

  always_comb begin
    unique case (tick_source_select)
      tccu_pkg::CS_STOP:     tick = 1'b0;
      tccu_pkg::CS_DIV1:     tick = 1'b1;
      tccu_pkg::CS_DIV8:     tick = tap8;
      tccu_pkg::CS_DIV64:    tick = tap64;
      tccu_pkg::CS_DIV256:   tick = tap256;
      tccu_pkg::CS_DIV1024:  tick = tap1024;
      tccu_pkg::CS_EXT_FALL: tick = ext_fall;
      tccu_pkg::CS_EXT_RISE: tick = ext_rise;
    endcase
  end

  // ****************************************************************
  // counter unit
  // ****************************************************************
  logic [7:0]             count_q;
  logic [7:0]             count_d;
  logic [7:0]             count_step;
  tccu_pkg::tccu_dir_t    dir_q;
  tccu_pkg::tccu_dir_t    dir_d;
  logic                   block_q;
  logic [7:0]             cmp_act_q [tccu_pkg::UNITS];
  logic [7:0]             cmp_buf_q [tccu_pkg::UNITS];
  logic [tccu_pkg::UNITS-1:0] match;

  wire       mode_fast  = tccu_is_fast(waveform_mode);
  wire       mode_pc    = tccu_is_pc(waveform_mode);
  wire       mode_ctc   = (waveform_mode == tccu_pkg::WGM_CTC);
  wire       top_is_cmp = mode_ctc || (waveform_mode == tccu_pkg::WGM_PC_OCRA) ||
                          (waveform_mode == tccu_pkg::WGM_FAST_OCRA);
  wire [7:0] top_val    = top_is_cmp ? cmp_act_q[0] : tccu_pkg::MAX;
  wire       at_top     = (count_q == top_val);
  wire       at_bottom  = (count_q == tccu_pkg::BOTTOM);
  wire       at_max     = (count_q == tccu_pkg::MAX);
  wire       going_down = (dir_q == tccu_pkg::TCCU_DOWN);
  wire       wrap       = tick && mode_fast && at_top;

  // counting sequence per mode
  always_comb begin
    count_step = count_q + 8'h01;
    dir_d      = dir_q;
    if (mode_ctc) begin
      count_step = match[0] ? tccu_pkg::BOTTOM : count_q + 8'h01;
    end else if (mode_fast) begin
      count_step = at_top ? tccu_pkg::BOTTOM : count_q + 8'h01;
    end else if (mode_pc) begin
      if (!going_down && at_top) begin
        dir_d      = tccu_pkg::TCCU_DOWN;
        count_step = count_q - 8'h01;
      end else if (going_down && at_bottom) begin
        dir_d      = tccu_pkg::TCCU_UP;
        count_step = count_q + 8'h01;
      end else begin
        count_step = going_down ? count_q - 8'h01 : count_q + 8'h01;
      end
    end
  end

  // cpu write has priority over any tick action
  assign count_d = count_wr ? count_wr_data : (tick ? count_step : count_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= tccu_pkg::COUNT_RST;
      dir_q   <= tccu_pkg::TCCU_UP;
    end else begin
      count_q <= count_d;
      dir_q   <= (tick && mode_pc) ? dir_d : (mode_pc ? dir_q : tccu_pkg::TCCU_UP);
    end
  end

  // a counter write arms a one-tick match block, held while stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      block_q <= 1'b0;
    end else if (count_wr) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // ****************************************************************
  // overflow flag
  // ****************************************************************
  logic overflow_q;

  wire ovf_set = tick && !count_wr &&
                 ((mode_fast && at_top) ||
                  (mode_pc && going_down && at_bottom) ||
                  (!mode_fast && !mode_pc && at_max));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_q <= tccu_pkg::FLAG_RST;
    end else begin
      overflow_q <= ovf_set | (overflow_q & ~(overflow_flag_wr_one | overflow_irq_ack));
    end
  end

  // ****************************************************************
  // compare units a and b
  // ****************************************************************
  logic [tccu_pkg::UNITS-1:0] cmp_wr;
  logic [7:0]                 cmp_wr_data [tccu_pkg::UNITS];
  logic [1:0]                 com         [tccu_pkg::UNITS];
  logic [tccu_pkg::UNITS-1:0] force_in;
  logic [tccu_pkg::UNITS-1:0] flag_clr;
  logic [tccu_pkg::UNITS-1:0] flag_q;
  logic [tccu_pkg::UNITS-1:0] oc_q;

  assign cmp_wr         = {compare_b_wr, compare_a_wr};
  assign cmp_wr_data[0] = compare_a_wr_data;
  assign cmp_wr_data[1] = compare_b_wr_data;
  assign com[0]         = output_action_field_a;
  assign com[1]         = output_action_field_b;
  assign force_in       = {force_match_strobe_b, force_match_strobe_a};
  assign flag_clr       = {match_flag_b_wr_one | match_b_irq_ack,
                           match_flag_a_wr_one | match_a_irq_ack};

  wire pwm_now    = tccu_is_pwm(waveform_mode);
  wire buf_load   = tick && pwm_now && at_top;

  genvar gi;
  generate
    for (gi = 0; gi < tccu_pkg::UNITS; gi++) begin : g_unit
      localparam logic UNIT_A = (gi == 0);

      wire cmp_eq    = (count_q == cmp_act_q[gi]);
      wire force_hit = force_in[gi] && !pwm_now;

      assign match[gi] = tick && cmp_eq && !block_q;

      // buffer always takes the write; active copy follows it directly outside pwm
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cmp_buf_q[gi] <= tccu_pkg::COMPARE_RST;
          cmp_act_q[gi] <= tccu_pkg::COMPARE_RST;
        end else begin
          if (cmp_wr[gi]) begin
            cmp_buf_q[gi] <= cmp_wr_data[gi];
          end
          if (cmp_wr[gi] && !pwm_now) begin
            cmp_act_q[gi] <= cmp_wr_data[gi];
          end else if (buf_load) begin
            cmp_act_q[gi] <= cmp_buf_q[gi];
          end
        end
      end

      // set wins over both clear paths
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          flag_q[gi] <= tccu_pkg::FLAG_RST;
        end else begin
          flag_q[gi] <= match[gi] | (flag_q[gi] & ~flag_clr[gi]);
        end
      end

      // mode changes do not touch the bit; only events do
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          oc_q[gi] <= tccu_pkg::OC_RST;
        end else begin
          oc_q[gi] <= tccu_oc_next(oc_q[gi], com[gi], waveform_mode, UNIT_A, going_down,
                                   match[gi], force_hit, wrap);
        end
      end

      // override looks only at the action field, never at the mode
      assign pin_out[gi] = (com[gi] != tccu_pkg::COM_NONE) ? oc_q[gi] : port_value[gi];
      assign pin_oe[gi]  = port_dir[gi];
    end
  endgenerate

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign count_value      = count_q;
  assign compare_value_a  = cmp_act_q[0];
  assign compare_value_b  = cmp_act_q[1];
  assign overflow_flag    = overflow_q;
  assign match_flag_a     = flag_q[0];
  assign match_flag_b     = flag_q[1];
  assign overflow_irq     = overflow_q & overflow_irq_en;
  assign match_a_irq      = flag_q[0] & match_a_irq_en;
  assign match_b_irq      = flag_q[1] & match_b_irq_en;
  assign compare_output_a = oc_q[0];
  assign compare_output_b = oc_q[1];

endmodule : tccu_timer0

`default_nettype wire

// *** rtl/tccu_pkg.sv ***
// Purpose: shared constants and types of the 8-bit timer/counter with two compare units
// Assumes: one system clock, asynchronous active-low reset
// Notes:   every offset-free control bit of the block is a plain port of tccu_timer0

package tccu_pkg;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned PRESC_W     = 10;
  localparam int unsigned UNITS       = 2;
  localparam logic [7:0]  BOTTOM      = 8'h00;
  localparam logic [7:0]  MAX         = 8'hFF;
  localparam logic [7:0]  COUNT_RST   = 8'h00;
  localparam logic [7:0]  COMPARE_RST = 8'h00;
  localparam logic        OC_RST      = 1'b0;
  localparam logic        FLAG_RST    = 1'b0;

  // ****************************************************************
  // tick source select codes
  // ****************************************************************
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // prescaler tap fires when the masked low bits are all ones
  localparam logic [9:0] TAP8_MASK    = 10'h007;
  localparam logic [9:0] TAP64_MASK   = 10'h03F;
  localparam logic [9:0] TAP256_MASK  = 10'h0FF;
  localparam logic [9:0] TAP1024_MASK = 10'h3FF;

  // ****************************************************************
  // waveform modes and output actions
  // ****************************************************************
  localparam logic [2:0] WGM_NORMAL    = 3'h0;
  localparam logic [2:0] WGM_PC_MAX    = 3'h1;
  localparam logic [2:0] WGM_CTC       = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX  = 3'h3;
  localparam logic [2:0] WGM_PC_OCRA   = 3'h5;
  localparam logic [2:0] WGM_FAST_OCRA = 3'h7;

  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic {
    TCCU_UP,
    TCCU_DOWN
  } tccu_dir_t;

endpackage : tccu_pkg

// *** rtl/tccu_ext_edge.sv ***
// Purpose: synchroniser and edge detector for the external count input
// Assumes: pin is asynchronous to clk
// Notes:   pulses are one clk cycle wide

`timescale 1ns/1ps
`default_nettype none

module tccu_ext_edge (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      rise_pulse,
  output logic      fall_pulse
);

  logic [tccu_pkg::SYNC_STAGES-1:0] sync_q;
  logic                             prev_q;
  logic                             rise_q;
  logic                             fall_q;

  // ****************************************************************
  // two-stage sampler, then history register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= '0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[tccu_pkg::SYNC_STAGES-2:0], pin_in};
      prev_q <= sync_q[tccu_pkg::SYNC_STAGES-1];
      rise_q <= sync_q[tccu_pkg::SYNC_STAGES-1] & ~prev_q;
      fall_q <= ~sync_q[tccu_pkg::SYNC_STAGES-1] & prev_q;
    end
  end

  assign rise_pulse = rise_q;
  assign fall_pulse = fall_q;

endmodule : tccu_ext_edge

`default_nettype wire

// *** verif/tccu_timer0_sva.sv ***
// Purpose: concurrent checks on the timer/counter top-level ports
// Assumes: one clk domain, asynchronous active-low rst_b
// Notes:   watches unit a, pin 0 and both pin directions; unit b is left to the bench
`timescale 1ns/1ps
`default_nettype none

module tccu_timer0_chk (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       external_count_input,
  input wire logic [2:0] tick_source_select,
  input wire logic [2:0] waveform_mode,
  input wire logic [1:0] output_action_field_a,
  input wire logic       count_wr,
  input wire logic [7:0] count_wr_data,
  input wire logic       match_a_irq_en,
  input wire logic [1:0] port_value,
  input wire logic [1:0] port_dir,
  input wire logic [7:0] count_value,
  input wire logic [7:0] compare_value_a,
  input wire logic       overflow_flag,
  input wire logic       match_flag_a,
  input wire logic       match_a_irq,
  input wire logic       compare_output_a,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  AST_STOP: assert property (tick_source_select == 3'h0 && !count_wr |=> $stable(count_value))
    else $error("counter moved while stopped");
  AST_WRITE: assert property (count_wr |=> count_value == $past(count_wr_data))
    else $error("counter write lost");
  AST_DIV1: assert property (tick_source_select == 3'h1 && waveform_mode == 3'h0 && !count_wr
    |=> count_value == $past(count_value) + 8'h01) else $error("no tick at full rate");
  AST_OVF: assert property (tick_source_select == 3'h1 && waveform_mode == 3'h0
    && count_value == 8'hFF && !count_wr |=> overflow_flag) else $error("overflow missed");
  // a write arms a block until the next tick, so require a tick on the previous edge too
  AST_MATCH: assert property (tick_source_select == 3'h1 && $past(tick_source_select) == 3'h1
    && !$past(count_wr) && !count_wr && count_value == compare_value_a |=> match_flag_a)
    else $error("match flag missed");
  AST_IRQ: assert property (match_a_irq == (match_flag_a && match_a_irq_en))
    else $error("irq not flag and enable");
  AST_PIN: assert property (pin_out[0] ==
    (output_action_field_a != 2'h0 ? compare_output_a : port_value[0]))
    else $error("pin source wrong");
  AST_OE: assert property (pin_oe == port_dir)
    else $error("pin direction wrong");
  AST_COM0: assert property (output_action_field_a == 2'h0 |=> $stable(compare_output_a))
    else $error("output moved with no action");
  AST_EXT: assert property (tick_source_select == 3'h7 && waveform_mode == 3'h0
    && $rose(external_count_input) |-> ##[3:4] $changed(count_value))
    else $error("external edge latency wrong");
endmodule : tccu_timer0_chk

bind tccu_timer0 tccu_timer0_chk tccu_timer0_chk_inst (
  .clk, .rst_b, .external_count_input, .tick_source_select, .waveform_mode,
  .output_action_field_a, .count_wr, .count_wr_data, .match_a_irq_en, .port_value,
  .port_dir, .count_value, .compare_value_a, .overflow_flag, .match_flag_a,
  .match_a_irq, .compare_output_a, .pin_out, .pin_oe
);

`default_nettype wire

// *** verif/tccu_ext_src.sv ***
// Purpose: external count source driving the count input pin
// Assumes: toggles only while en is high, holds its level otherwise
// Notes:   half period is HALF clk cycles
`timescale 1ns/1ps
`default_nettype none

module tccu_ext_src #(
  parameter int HALF = 3
) (
  input  wire logic clk,
  input  wire logic en,
  output logic      pin
);
  int   cnt = 0;
  logic lvl = 1'b0;

  assign pin = lvl;

  // each half period stays above one clk cycle and below clk/2.5 overall
  always @(posedge clk) begin
    if (!en) begin
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : tccu_ext_src

`default_nettype wire

// *** verif/tccu_timer0_tb.sv ***
// Purpose: directed bench for the timer/counter with two compare units
// Assumes: inputs driven at the falling edge, 100 ns clock
// Notes:   phase-correct runs only with top at max; top-from-compare pwm modes 5 and 7 are not exercised
`timescale 1ns/1ps
`default_nettype none

module tccu_timer0_tb;
  logic       clk = 1'b0;
  logic       rst_b, ext_en, external_count_input, oc_exp;
  logic [2:0] tick_source_select, waveform_mode;
  logic [1:0] output_action_field_a, output_action_field_b, port_value, port_dir;
  logic       force_match_strobe_a, force_match_strobe_b, count_wr, compare_a_wr, compare_b_wr;
  logic [7:0] count_wr_data, compare_a_wr_data, compare_b_wr_data;
  logic       overflow_flag_wr_one, match_flag_a_wr_one, match_flag_b_wr_one;
  logic       overflow_irq_ack, match_a_irq_ack, match_b_irq_ack;
  logic       overflow_irq_en, match_a_irq_en, match_b_irq_en;
  logic [7:0] count_value, compare_value_a, compare_value_b;
  logic       overflow_flag, match_flag_a, match_flag_b;
  logic       overflow_irq, match_a_irq, match_b_irq, compare_output_a, compare_output_b;
  logic [1:0] pin_out, pin_oe;
  logic [1:0] acts [5] = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h0};
  int         divs [4] = '{8, 64, 256, 1024};
  int         num_errors = 0;
  int         samples_checked = 0;

  tccu_timer0 tccu_timer0_inst (
    .clk, .rst_b, .external_count_input, .tick_source_select, .waveform_mode,
    .output_action_field_a, .output_action_field_b, .force_match_strobe_a,
    .force_match_strobe_b, .count_wr, .count_wr_data, .compare_a_wr, .compare_a_wr_data,
    .compare_b_wr, .compare_b_wr_data, .overflow_flag_wr_one, .match_flag_a_wr_one,
    .match_flag_b_wr_one, .overflow_irq_ack, .match_a_irq_ack, .match_b_irq_ack,
    .overflow_irq_en, .match_a_irq_en, .match_b_irq_en, .port_value, .port_dir,
    .count_value, .compare_value_a, .compare_value_b, .overflow_flag, .match_flag_a,
    .match_flag_b, .overflow_irq, .match_a_irq, .match_b_irq, .compare_output_a,
    .compare_output_b, .pin_out, .pin_oe
  );

  tccu_ext_src tccu_ext_src_inst (.clk, .en(ext_en), .pin(external_count_input));

  always #50 clk = ~clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // sel 0 counter, 1 compare a, 2 compare b
  task automatic wr(input logic [1:0] sel, input logic [7:0] v);
    @(negedge clk);
    count_wr          = (sel == 2'h0);
    compare_a_wr      = (sel == 2'h1);
    compare_b_wr      = (sel == 2'h2);
    count_wr_data     = v;
    compare_a_wr_data = v;
    compare_b_wr_data = v;
    @(negedge clk);
    {count_wr, compare_a_wr, compare_b_wr} = 3'h0;
  endtask : wr

  task automatic run(input logic [2:0] cs, input int n);
    @(negedge clk);
    tick_source_select = cs;
    cyc(n);
    tick_source_select = 3'h0;
  endtask : run

  task automatic end_sim;
    $display("mismatches %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    #500000;
    num_errors++;
    end_sim();
  end

  initial begin
    {count_wr, compare_a_wr, compare_b_wr, force_match_strobe_a, force_match_strobe_b,
     overflow_flag_wr_one, match_flag_a_wr_one, match_flag_b_wr_one, overflow_irq_ack,
     match_a_irq_ack, match_b_irq_ack, match_b_irq_en, ext_en, rst_b, tick_source_select,
     waveform_mode, output_action_field_a, output_action_field_b, port_value,
     count_wr_data, compare_a_wr_data, compare_b_wr_data} = '0;
    {overflow_irq_en, match_a_irq_en} = 2'h3;
    port_dir = 2'h3;
    cyc(3);
    rst_b = 1'b1;
    chk(count_value, 8'h00);
    chk(8'({compare_output_a, compare_output_b, match_flag_a, match_flag_b}), 8'h00);
    chk(8'(pin_oe), 8'h03);
    wr(2'h0, 8'h10);
    run(3'h0, 5);
    chk(count_value, 8'h10);
    run(3'h1, 4);
    chk(count_value, 8'h14);
    wr(2'h1, 8'h20);
    wr(2'h2, 8'h20);
    chk(compare_value_b, 8'h20);
    wr(2'h0, 8'h20);
    run(3'h1, 1);
    chk(8'({count_value[6:0], match_flag_a | match_flag_b}), 8'h42);
    wr(2'h0, 8'h1E);
    run(3'h1, 3);
    chk(count_value, 8'h21);
    chk(8'({match_flag_a, match_flag_b, match_a_irq, match_b_irq}), 8'h0E);
    match_b_irq_en = 1'b1;
    cyc(1);
    chk(8'(match_b_irq), 8'h01);
    wr(2'h0, 8'hFE);
    run(3'h1, 2);
    chk(8'({count_value[6:0], overflow_flag, overflow_irq}), 8'h03);
    waveform_mode = 3'h2;
    wr(2'h1, 8'h05);
    wr(2'h0, 8'h03);
    run(3'h1, 3);
    chk(count_value, 8'h00);
    @(negedge clk);
    {match_flag_a_wr_one, match_b_irq_ack, overflow_irq_ack} = 3'h7;
    @(negedge clk);
    {match_flag_a_wr_one, match_b_irq_ack, overflow_irq_ack} = 3'h0;
    chk(8'({overflow_flag, match_flag_a, match_flag_b}), 8'h00);
    waveform_mode = 3'h0;
    port_value = 2'h2;
    oc_exp = 1'b0;
    foreach (acts[i]) begin
      @(negedge clk);
      output_action_field_a = acts[i];
      force_match_strobe_a = 1'b1;
      @(negedge clk);
      force_match_strobe_a = 1'b0;
      if (acts[i] == 2'h1) begin
        oc_exp = ~oc_exp;
      end else if (acts[i] != 2'h0) begin
        oc_exp = acts[i][0];
      end
      chk(8'(compare_output_a), 8'(oc_exp));
      chk(8'(pin_out[0]), 8'(acts[i] != 2'h0 ? oc_exp : port_value[0]));
    end
    wr(2'h0, 8'h33);
    output_action_field_b = 2'h3;
    force_match_strobe_b = 1'b1;
    cyc(1);
    force_match_strobe_b = 1'b0;
    chk(8'({compare_output_b, pin_out[1]}), 8'h03);
    chk(8'({count_value[6:0], match_flag_a}), 8'h66);
    waveform_mode = 3'h3;
    output_action_field_a = 2'h2;
    force_match_strobe_a = 1'b1;
    cyc(1);
    force_match_strobe_a = 1'b0;
    chk(8'(compare_output_a), 8'(oc_exp));
    wr(2'h1, 8'h40);
    chk(compare_value_a, 8'h05);
    wr(2'h0, 8'hFE);
    run(3'h1, 2);
    chk(compare_value_a, 8'h40);
    waveform_mode = 3'h1;
    wr(2'h0, 8'hFE);
    run(3'h1, 3);
    chk(count_value, 8'hFD);
    waveform_mode = 3'h0;
    wr(2'h0, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      tick_source_select = 3'(7 - i);
      ext_en = 1'b1;
      cyc(12);
      ext_en = 1'b0;
      cyc(5);
      chk(count_value, 8'(2 * i + 2));
    end
    tick_source_select = 3'h0;
    foreach (divs[i]) begin
      wr(2'h0, 8'h00);
      run(3'(i + 2), divs[i] + 1);
      chk(8'(count_value == 8'h01 || count_value == 8'h02), 8'h01);
    end
    end_sim();
  end
endmodule : tccu_timer0_tb

`default_nettype wire
